// *** wake_edge_map.vh ***
// register offsets, field positions and reset values of the wake edge block
`ifndef WAKE_EDGE_MAP_VH
`define WAKE_EDGE_MAP_VH
`define WE_OFF_SELECT      4'h0
`define WE_OFF_STATUS      4'h4
`define WE_OFF_MASK        4'h8
`define WE_OFF_LEVEL       4'hC
`define WE_PIN_COUNT       6
`define WE_SEL_RESERVED    2'h3
`define WE_SEL_RESET       6'h00
`define WE_STATUS_RESET    6'h00
`define WE_MASK_RESET      6'h00
`define WE_PIN_IDLE        6'h3F
`define WE_RESP_OKAY       2'h0
`define WE_RESP_SLVERR     2'h2
`endif

// *** edge_detect_bit.v ***
// one wake pin: two stage synchroniser and selectable edge pulse
`timescale 1ns/1ps
module edge_detect_bit (
   // clock and reset
   input  wire aclk,
   input  wire aresetn,
   // pin and selection
   input  wire pin_in,
   input  wire rising_sel,
   // detected edge, one cycle
   output reg  edge_pulse_r
);
   reg sync1_r;
   reg sync2_r;
   reg prev_r;
   reg edge_pulse_nxt;

   // pulse when the settled level moves the chosen way
   always @* begin
      if (rising_sel) begin
         edge_pulse_nxt = sync2_r & ~prev_r;
      end else begin
         edge_pulse_nxt = ~sync2_r & prev_r;
      end
   end

   // synchroniser, previous sample and pulse register; idle level is high
   always @(posedge aclk) begin
      if (!aresetn) begin
         sync1_r      <= 1'b1;
         sync2_r      <= 1'b1;
         prev_r       <= 1'b1;
         edge_pulse_r <= 1'b0;
      end else begin
         sync1_r      <= pin_in;
         sync2_r      <= sync1_r;
         prev_r       <= sync2_r;
         edge_pulse_r <= edge_pulse_nxt;
      end
   end
endmodule // edge_detect_bit

// *** wake_pin_edge_select.v ***
// wake pin edge select register, edge detectors, status, mask and interrupt
//
// How it works
// - the select register picks the interrupt edge for each of six wake pins
// - bits 7 and 6 of the select register ignore writes and read one
// - bit 4 picks pin 4 edge; zero falling at reset, one rising
// - bit 3 picks pin 3 edge; zero falling at reset, one rising
// - bit 2 picks pin 2 edge; zero falling at reset, one rising
// - bit 1 picks pin 1 edge; zero falling at reset, one rising
// - bit 0 picks pin 0 edge; zero falling at reset, one rising
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "wake_edge_map.vh"
module wake_pin_edge_select (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // axi4-lite write address
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // axi4-lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read address
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // axi4-lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // wake pins, pin 0 to pin 5, one input each
   input  wire        wake_in_0,
   input  wire        wake_in_1,
   input  wire        wake_in_2,
   input  wire        wake_in_3,
   input  wire        wake_in_4,
   input  wire        wake_in_5,
   // per pin request pulses and combined interrupt
   output wire [5:0]  wake_req,
   output reg         irq_r
);
   // ****************************************************************
   // registers and write path state
   // ****************************************************************
   reg  [5:0]  wake_edge_select_r;
   reg  [5:0]  status_r;
   reg  [5:0]  status_nxt;
   reg  [5:0]  mask_r;
   reg  [3:0]  aw_addr_r;
   reg         aw_have_r;
   reg  [31:0] w_data_r;
   reg  [3:0]  w_strb_r;
   reg         w_have_r;
   reg  [31:0] rdata_nxt;
   reg  [1:0]  rresp_nxt;
   wire [5:0]  pins;
   wire [5:0]  edge_hit;
   wire        wr_fire;
   wire        rd_fire;

   assign pins     = {wake_in_5, wake_in_4, wake_in_3, wake_in_2, wake_in_1, wake_in_0};
   assign wake_req = edge_hit; // each bit is a detector flip-flop

   // ****************************************************************
   // one detector per pin, edge chosen by its select bit
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < `WE_PIN_COUNT; gi = gi + 1) begin : g_pin
         edge_detect_bit u_det (
            .aclk         (aclk),
            .aresetn      (aresetn),
            .pin_in       (pins[gi]),
            .rising_sel   (wake_edge_select_r[gi]),
            .edge_pulse_r (edge_hit[gi])
         );
      end
   endgenerate

   // ****************************************************************
   // axi4-lite write channel
   // ****************************************************************
   assign wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;

   // capture address and data in either order, answer when both held
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_have_r     <= 1'b0;
         w_have_r      <= 1'b0;
         aw_addr_r     <= 4'h0;
         w_data_r      <= 32'h00000000;
         w_strb_r      <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `WE_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_r     <= s_axi_awaddr;
            aw_have_r     <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_r     <= s_axi_wdata;
            w_strb_r     <= s_axi_wstrb;
            w_have_r     <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr_r == `WE_OFF_LEVEL) begin
               s_axi_bresp <= `WE_RESP_SLVERR; // level register is read only
            end else begin
               s_axi_bresp <= `WE_RESP_OKAY;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // select and mask registers; only byte lane 0 holds bits
   always @(posedge aclk) begin
      if (!aresetn) begin
         wake_edge_select_r <= `WE_SEL_RESET;
         mask_r             <= `WE_MASK_RESET;
      end else if (wr_fire && w_strb_r[0]) begin
         if (aw_addr_r == `WE_OFF_SELECT) begin
            wake_edge_select_r <= w_data_r[5:0];
         end
         if (aw_addr_r == `WE_OFF_MASK) begin
            mask_r <= w_data_r[5:0];
         end
      end
   end

   // ****************************************************************
   // axi4-lite read channel
   // ****************************************************************
   assign rd_fire = s_axi_arvalid & s_axi_arready;

   // read mux; reserved select bits read one, unmapped gives slverr
   always @* begin
      rdata_nxt = 32'h00000000;
      rresp_nxt = `WE_RESP_OKAY;
      case (s_axi_araddr)
         `WE_OFF_SELECT: rdata_nxt = {24'h000000, `WE_SEL_RESERVED, wake_edge_select_r};
         `WE_OFF_STATUS: rdata_nxt = {26'h0000000, status_r};
         `WE_OFF_MASK:   rdata_nxt = {26'h0000000, mask_r};
         `WE_OFF_LEVEL:  rdata_nxt = {26'h0000000, pins};
         default:        rresp_nxt = `WE_RESP_SLVERR;
      endcase
   end

   // one read at a time; address taken, data one cycle later
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `WE_RESP_OKAY;
      end else begin
         if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdata_nxt;
            s_axi_rresp   <= rresp_nxt;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // sticky status, clear on read, masked interrupt
   // ****************************************************************
   always @* begin
      status_nxt = status_r;
      if (rd_fire && s_axi_araddr == `WE_OFF_STATUS) begin
         status_nxt = `WE_STATUS_RESET;
      end
      status_nxt = status_nxt | edge_hit; // new edge wins over the clear
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= `WE_STATUS_RESET;
         irq_r    <= 1'b0;
      end else begin
         status_r <= status_nxt;
         irq_r    <= |(status_nxt & mask_r);
      end
   end
endmodule // wake_pin_edge_select

// *** wake_edge_checker_assertions.sv ***
// assertion checker for the wake pin edge select block
`timescale 1ns/1ps
module wake_edge_checker (
   input wire        aclk, aresetn, irq_r, s_axi_bvalid, s_axi_bready,
   input wire        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
   input wire        wake_in_0, wake_in_1, wake_in_2, wake_in_3, wake_in_4, wake_in_5,
   input wire [3:0]  s_axi_araddr,
   input wire [31:0] s_axi_rdata,
   input wire [5:0]  wake_req
);
   // pin levels gathered into one vector
   wire [5:0] pv = {wake_in_5, wake_in_4, wake_in_3, wake_in_2, wake_in_1, wake_in_0};
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // a pin change sampled at edge n gives a request sampled at edge n+3
   req_cause_a: assert property ($past(aresetn, 5) |-> (wake_req & ~($past(pv, 3) ^ $past(pv, 4))) == 6'h00)
      else $error("request without pin edge");
   req_single_a: assert property ((wake_req & $past(wake_req)) == 6'h00)
      else $error("request longer than one cycle");
   rst_quiet_a: assert property ($rose(aresetn) |-> !irq_r && wake_req == 6'h00 && s_axi_arready)
      else $error("outputs not quiet after reset");
   sel_reserved_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h0 |=>
      s_axi_rvalid && s_axi_rdata[7:6] == 2'h3) else $error("reserved select bits not one");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   ar_busy_a: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready && s_axi_rvalid)
      else $error("read not answered next cycle");
   irq_clear_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h4 |=>
      !irq_r || $past(wake_req) != 6'h00) else $error("interrupt kept after status read");
endmodule // wake_edge_checker
bind wake_pin_edge_select wake_edge_checker chk (.*);

// *** wake_pins_model.sv ***
// far side model: six wake pins, idle high, following the bench one edge later
`timescale 1ns/1ps
module wake_pins_model (
   input  wire       aclk,
   input  wire [5:0] want,
   output wire       wake_in_0, wake_in_1, wake_in_2, wake_in_3, wake_in_4, wake_in_5
);
   reg [5:0] lvl_r = 6'h3F;
   // pin levels move just after a clock edge
   always @(posedge aclk) begin
      lvl_r <= want;
   end
   assign {wake_in_5, wake_in_4, wake_in_3, wake_in_2, wake_in_1, wake_in_0} = lvl_r;
endmodule // wake_pins_model

// *** test_wake_pin_edge_select.sv ***
// self-checking testbench for the wake pin edge select block
`timescale 1ns/1ps
`include "wake_edge_map.vh"
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin err_total = err_total + 1; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_wake_pin_edge_select;
   reg         aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   reg  [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   reg  [31:0] s_axi_wdata = 32'h0, d;
   reg  [5:0]  want = 6'h3F, sel, msk;
   reg  [1:0]  r;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_r;
   wire        wake_in_0, wake_in_1, wake_in_2, wake_in_3, wake_in_4, wake_in_5;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [5:0]  wake_req;
   integer     err_total = 0, compares = 0, cyc = 0, hits = 0, other = 0, p = 0, k;
   wake_pins_model pm (.*);
   wake_pin_edge_select dut (.*);
   always #25 aclk = ~aclk;
   // request counting on the pin under test and the others, plus timeout
   always @(posedge aclk) begin
      cyc = cyc + 1;
      hits = hits + wake_req[p];
      other = other + |(wake_req & ~(6'h01 << p));
      if (cyc == 5000) begin err_total = err_total + 1; results; end
   end
   // one write, address and data offered together
   task wr(input [3:0] a, input [31:0] v); begin
      s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      do begin @(posedge aclk); if (s_axi_awready) s_axi_awvalid <= 1'b0; if (s_axi_wready) s_axi_wvalid <= 1'b0; end
      while (s_axi_awvalid | s_axi_wvalid);
      do @(posedge aclk); while (!s_axi_bvalid);
      r = s_axi_bresp; s_axi_bready <= 1'b0;
   end endtask
   // one read, data and response left in d and r
   task rd(input [3:0] a); begin
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 1'b0;
   end endtask
   task results; begin
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   end endtask
   // main sequence
   initial begin
      k = $urandom(73);
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      wr(`WE_OFF_SELECT, 32'h00000015);
      rd(`WE_OFF_SELECT); `CHK(d, 32'h000000D5)
      rd(4'h2); `CHK({r, d}, {`WE_RESP_SLVERR, 32'h0})
      wr(`WE_OFF_LEVEL, 32'h0); `CHK(r, `WE_RESP_SLVERR)
      for (k = 0; k < 3; k = k + 1) begin
         sel = (k == 0) ? 6'h00 : (k == 1) ? 6'h3F : $urandom;
         msk = (k == 2) ? $urandom : 6'h3F;
         wr(`WE_OFF_SELECT, {26'h0, sel}); wr(`WE_OFF_MASK, {26'h0, msk});
         for (p = 0; p < 6; p = p + 1) begin
            hits = 0; other = 0; want[p] <= 1'b0; repeat (7) @(posedge aclk);
            `CHK(hits, !sel[p])
            `CHK(irq_r, msk[p] & !sel[p])
            want[p] <= 1'b1; repeat (7) @(posedge aclk);
            `CHK({hits[3:0], other[3:0]}, 8'h10)
            rd(`WE_OFF_STATUS); `CHK(d, 32'h1 << p)
            `CHK(irq_r, 1'b0)
            rd(`WE_OFF_STATUS); `CHK(d, 32'h0)
         end
         $display("edge pass %0d done", k);
      end
      aresetn <= 1'b0; repeat (2) @(posedge aclk); aresetn <= 1'b1;
      rd(`WE_OFF_SELECT); `CHK(d, 32'h000000C0)
      $display("reset test done");
      results;
   end
endmodule // test_wake_pin_edge_select
